// ---- bench/pin_source_model.sv ----
// Signal sources and load on the two timer pins
`timescale 1ns/1ps
`default_nettype none
module pin_source_model (
  input wire logic src_a,
  input wire logic src_b,
  input wire logic pin_a_out,
  input wire logic pin_a_oe_n,
  output logic pin_a_wire,
  output logic pin_b_wire
);
  // Block owns pin A only while its enable is low
  assign pin_a_wire = pin_a_oe_n ? src_a : pin_a_out;
  // Pin B is only ever an input
  assign pin_b_wire = src_b;
endmodule
`default_nettype wire

// ---- bench/tb.sv ----
// Self-checking bench for the multimode timer
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk, rst_n, ctrl_wr, cnt_wr, reg_a_wr, reg_b_wr, clr_pending_a, clr_pending_b;
  logic irq_enable_a, irq_enable_b, src_a, src_b, pin_a_wire, pin_b_wire;
  logic timer_pin_a_out, timer_pin_a_oe_n, pending_a, pending_b, irq_a, irq_b;
  logic [7:0] ctrl_wdata, timer_control_reg;
  logic [15:0] cnt_wdata, reg_wdata, main_counter, reload_capture_a, reload_capture_b;
  logic [7:0] codes [4] = '{8'h40, 8'hC0, 8'hE0, 8'h60};
  int miscompares = 0;
  int samples_checked = 0;
  int n;
  logic [15:0] lag; // Counter steps since a capture, less the expected minimum
  // ********************************
  // Clock, design and pin sources
  // ********************************
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  multimode_timer_pwm_capture uut (.clk(clk), .rst_n(rst_n), .ctrl_wr(ctrl_wr), .ctrl_wdata(ctrl_wdata),
    .cnt_wr(cnt_wr), .cnt_wdata(cnt_wdata), .reg_a_wr(reg_a_wr), .reg_b_wr(reg_b_wr), .reg_wdata(reg_wdata),
    .clr_pending_a(clr_pending_a), .clr_pending_b(clr_pending_b), .irq_enable_a(irq_enable_a),
    .irq_enable_b(irq_enable_b), .timer_pin_a_in(pin_a_wire), .timer_pin_b(pin_b_wire),
    .timer_pin_a_out(timer_pin_a_out), .timer_pin_a_oe_n(timer_pin_a_oe_n),
    .timer_control_reg(timer_control_reg), .main_counter(main_counter), .reload_capture_a(reload_capture_a),
    .reload_capture_b(reload_capture_b), .pending_a(pending_a), .pending_b(pending_b), .irq_a(irq_a),
    .irq_b(irq_b));
  pin_source_model src (.src_a(src_a), .src_b(src_b), .pin_a_out(timer_pin_a_out),
    .pin_a_oe_n(timer_pin_a_oe_n), .pin_a_wire(pin_a_wire), .pin_b_wire(pin_b_wire));
  // ********************************
  // Access tasks
  // ********************************
  task automatic cyc(input int k);
    repeat (k) @(negedge clk);
  endtask
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic write_ctrl(input logic [7:0] v);
    ctrl_wdata = v;
    ctrl_wr = 1'b1;
    cyc(1);
    ctrl_wr = 1'b0;
    cyc(1);
  endtask
  task automatic write_cnt(input logic [15:0] v);
    cnt_wdata = v;
    cnt_wr = 1'b1;
    cyc(1);
    cnt_wr = 1'b0;
    cyc(1);
  endtask
  task automatic write_words(input logic [15:0] va, input logic [15:0] vb);
    reg_wdata = va;
    reg_a_wr = 1'b1;
    cyc(1);
    reg_a_wr = 1'b0;
    reg_wdata = vb;
    reg_b_wr = 1'b1;
    cyc(1);
    reg_b_wr = 1'b0;
    cyc(1);
  endtask
  task automatic clear_flags();
    {clr_pending_a, clr_pending_b} = 2'h3;
    cyc(1);
    {clr_pending_a, clr_pending_b} = 2'h0;
    cyc(1);
  endtask
  // Wait for a pending flag under a bounded count
  task automatic wait_flag(input bit b);
    n = 0;
    while (((b ? pending_b : pending_a) !== 1'b1) && n < 3000) begin
      cyc(1);
      n++;
    end
    check("flag_wait", 16'(n < 3000), 16'h1);
  endtask
  // One full pulse on pin A gives one edge of each kind
  task automatic pulse_a();
    src_a = 1'b1;
    cyc(25);
    src_a = 1'b0;
    cyc(25);
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // ********************************
  // Watchdog
  // ********************************
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    end_of_test();
  end
  // ********************************
  // Test sequence
  // ********************************
  initial begin
    {ctrl_wr, cnt_wr, reg_a_wr, reg_b_wr, clr_pending_a, clr_pending_b} = 6'h00;
    {irq_enable_a, irq_enable_b, src_a, src_b} = 4'h0;
    ctrl_wdata = 8'h00;
    cnt_wdata = 16'h0000;
    reg_wdata = 16'h0000;
    rst_n = 1'b0;
    cyc(8);
    rst_n = 1'b1;
    cyc(1);
    check("ctrl_reset", 16'(timer_control_reg), 16'h0000);
    check("oe_reset", 16'(timer_pin_a_oe_n), 16'h1);
    // PWM with toggle: A then B then A reloads
    write_words(16'h0003, 16'h0005);
    write_cnt(16'h0000);
    irq_enable_a = 1'b1;
    write_ctrl(8'hB0);
    wait_flag(1'b0);
    check("first_reload", main_counter, 16'h0003);
    check("pin_toggle", 16'(pin_a_wire), 16'h1);
    cyc(2);
    check("irq_a_on", 16'(irq_a), 16'h1);
    clear_flags();
    wait_flag(1'b1);
    check("a_to_b_span", 16'(n), 16'd36);
    check("second_reload", main_counter, 16'h0005);
    check("pin_back", 16'(pin_a_wire), 16'h0);
    cyc(2);
    check("irq_b_masked", 16'(irq_b), 16'h0);
    clear_flags();
    wait_flag(1'b0);
    check("b_to_a_span", 16'(n), 16'd56);
    check("third_reload", main_counter, 16'h0003);
    // Plain PWM then stop
    write_ctrl(8'h90);
    cyc(40);
    check("plain_no_drive", 16'(timer_pin_a_oe_n), 16'h1);
    write_ctrl(8'h80);
    cyc(30);
    check("stopped_hold", main_counter, 16'h0005);
    // Event counting on both edge codes
    irq_enable_b = 1'b1;
    for (int i = 0; i < 2; i++) begin
      write_ctrl(8'h00);
      write_cnt(16'h0002);
      clear_flags();
      write_ctrl(i ? 8'h30 : 8'h10);
      pulse_a();
      pulse_a();
      check("event_count", main_counter, 16'h0000);
      check("event_no_flag", 16'(pending_a), 16'h0);
      pulse_a();
      check("event_reload", main_counter, 16'h0003);
      check("event_flag", 16'(pending_a), 16'h1);
      check("event_no_drive", 16'(timer_pin_a_oe_n), 16'h1);
    end
    src_b = 1'b1;
    cyc(25);
    src_b = 1'b0;
    cyc(5);
    check("pin_b_flag", 16'(pending_b), 16'h1);
    check("pin_b_irq", 16'(irq_b), 16'h1);
    // Capture edges per code, pins judged apart
    foreach (codes[i]) begin
      write_ctrl(codes[i]);
      clear_flags();
      {src_a, src_b} = 2'h3;
      cyc(30);
      check("cap_a_rise", 16'(pending_a), 16'(codes[i][7:5] != 3'h7 && codes[i][7:5] != 3'h3));
      check("cap_b_rise", 16'(pending_b), 16'(codes[i][7:5] == 3'h2));
      {src_a, src_b} = 2'h0;
      cyc(30);
      check("cap_a_flag", 16'(pending_a), 16'h1);
      check("cap_b_flag", 16'(pending_b), 16'h1);
      // Rising captures are 5 or 6 ticks old at this point, falling captures 2 or 3
      lag = reload_capture_a - main_counter - (codes[i][5] ? 16'h0002 : 16'h0005);
      check("cap_a_value", 16'(lag <= 16'h0001), 16'h1);
      lag = reload_capture_b - main_counter - ((codes[i][7:5] == 3'h2) ? 16'h0005 : 16'h0002);
      check("cap_b_value", 16'(lag <= 16'h0001), 16'h1);
    end
    // Capture underflow sets the run bit
    write_ctrl(8'h40);
    clear_flags();
    write_cnt(16'h0001);
    cyc(25);
    check("underflow_bit", 16'(timer_control_reg), 16'h0050);
    check("underflow_irq", 16'(irq_a), 16'h1);
    write_ctrl(8'h40);
    cyc(2);
    check("underflow_clear", 16'(timer_control_reg), 16'h0040);
    end_of_test();
  end
endmodule
bind multimode_timer_pwm_capture timer_checker #(.CNT_W(CNT_W)) chk (.clk(clk), .rst_n(rst_n),
  .ctrl_wr(ctrl_wr), .ctrl_wdata(ctrl_wdata), .cnt_wr(cnt_wr), .reg_a_wr(reg_a_wr), .reg_wdata(reg_wdata),
  .clr_pending_a(clr_pending_a), .irq_enable_b(irq_enable_b), .timer_pin_a_out(timer_pin_a_out),
  .timer_pin_a_oe_n(timer_pin_a_oe_n), .timer_control_reg(timer_control_reg), .main_counter(main_counter),
  .reload_capture_a(reload_capture_a), .reload_capture_b(reload_capture_b), .pending_a(pending_a),
  .pending_b(pending_b), .irq_b(irq_b));
`default_nettype wire

// ---- bench/timer_checker.sv ----
// Port checker for the multimode timer
`timescale 1ns/1ps
`default_nettype none
module timer_checker #(
  parameter int CNT_W = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ctrl_wr,
  input wire logic [7:0] ctrl_wdata,
  input wire logic cnt_wr,
  input wire logic reg_a_wr,
  input wire logic [CNT_W-1:0] reg_wdata,
  input wire logic clr_pending_a,
  input wire logic irq_enable_b,
  input wire logic timer_pin_a_out,
  input wire logic timer_pin_a_oe_n,
  input wire logic [7:0] timer_control_reg,
  input wire logic [CNT_W-1:0] main_counter,
  input wire logic [CNT_W-1:0] reload_capture_a,
  input wire logic [CNT_W-1:0] reload_capture_b,
  input wire logic pending_a,
  input wire logic pending_b,
  input wire logic irq_b
);
  // ********************************
  // Clocking and helpers
  // ********************************
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // PWM mode with the run bit set
  logic pwm_run;
  assign pwm_run = (timer_control_reg[7:6] == 2'h2) && timer_control_reg[4];
  // One counting step of a running PWM counter
  sequence s_pwm_tick;
    $changed(main_counter) && pwm_run && !$past(cnt_wr);
  endsequence
  // Toggle mode held over two cycles, counter leaving zero
  sequence s_toggle_reload;
    (timer_control_reg[7:4] == 4'hB) && $past(timer_control_reg[7:4] == 4'hB)
      && ($past(main_counter) == '0) && (main_counter != '0);
  endsequence
  // ********************************
  // Properties
  // ********************************
  // The readback byte trails the internal bits by one cycle, so the written code shows two edges on
  property p_ctrl_store;
    ctrl_wr |-> ##2 timer_control_reg[7:5] == $past(ctrl_wdata[7:5], 2) && timer_control_reg[3:0] == 4'h0;
  endproperty
  a_ctrl_store: assert property (p_ctrl_store) else $error("control bits not stored");
  property p_irq_b;
    irq_b == $past(irq_enable_b && pending_b);
  endproperty
  a_irq_b: assert property (p_irq_b) else $error("irq b not gated by enable");
  property p_flag_sticky;
    $fell(pending_a) |-> $past(clr_pending_a);
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("pending a dropped without clear");
  property p_pin_released;
    (timer_control_reg[7:5] != 3'h5) && $past(timer_control_reg[7:5] != 3'h5) |-> timer_pin_a_oe_n;
  endproperty
  a_pin_released: assert property (p_pin_released) else $error("pin a driven outside toggle");
  property p_stop_hold;
    (timer_control_reg[7:4] == 4'h8 || timer_control_reg[7:4] == 4'hA) && !$past(cnt_wr) |-> $stable(main_counter);
  endproperty
  a_stop_hold: assert property (p_stop_hold) else $error("stopped counter moved");
  property p_word_write;
    reg_a_wr ##1 !timer_control_reg[6] |-> reload_capture_a == $past(reg_wdata);
  endproperty
  a_word_write: assert property (p_word_write) else $error("word a write lost");
  property p_pwm_step;
    s_pwm_tick |-> (main_counter == $past(main_counter) - 1'b1) || ($past(main_counter) == '0
      && (main_counter == reload_capture_a || main_counter == reload_capture_b));
  endproperty
  a_pwm_step: assert property (p_pwm_step) else $error("bad pwm counter step");
  property p_tick_spacing;
    s_pwm_tick |=> $stable(main_counter) [*8];
  endproperty
  a_tick_spacing: assert property (p_tick_spacing) else $error("pwm steps too close");
  property p_toggle;
    s_toggle_reload |-> timer_pin_a_out != $past(timer_pin_a_out);
  endproperty
  a_toggle: assert property (p_toggle) else $error("pin a not toggled on reload");
endmodule
`default_nettype wire

// ---- common/timer_params.svh ----
// Named constants for the multimode timer block
`ifndef TIMER_PARAMS_SVH
`define TIMER_PARAMS_SVH

// Control register data address
`define TMR_CTRL_ADDR 16'h00EE
// Control register value after reset
`define TMR_CTRL_RESET 4'h0
// Bit positions of the timer bits in the control byte
`define TMR_BIT_MODE3 7
`define TMR_BIT_MODE2 6
`define TMR_BIT_MODE1 5
`define TMR_BIT_RUN 4
// Input clock cycles per instruction cycle
`define TMR_CKI_DIV 10
// Counter and register width
`define TMR_CNT_W 16
`define TMR_CNT_ZERO 16'h0000
`define TMR_CNT_ONE 16'h0001
// Prescaler width and constants
`define TMR_PRESC_W 4
`define TMR_PRESC_ZERO 4'h0
`define TMR_PRESC_ONE 4'h1

`endif

// ---- common/timer_pkg.sv ----
// Types shared by the multimode timer block
package timer_pkg;

  // Mode bits 3..1 as one code
  typedef enum logic [2:0] {
    CODE_EVENT_RISE = 3'h0,
    CODE_EVENT_FALL = 3'h1,
    CODE_CAP_RR = 3'h2,
    CODE_CAP_FF_ALT = 3'h3,
    CODE_PWM_PLAIN = 3'h4,
    CODE_PWM_TOGGLE = 3'h5,
    CODE_CAP_RF = 3'h6,
    CODE_CAP_FF = 3'h7
  } mode_code_type;

  // Which register feeds the next PWM reload
  typedef enum logic {
    SRC_A = 1'h0,
    SRC_B = 1'h1
  } reload_src_type;

endpackage

// ---- logic/multimode_timer_pwm_capture.sv ----
// Multimode 16-bit timer: PWM, event counter and input capture
`timescale 1ns/1ps
`default_nettype none
`include "timer_params.svh"

// What this block does
// - PWM mode counts down each instruction cycle
// - First reload from A, then B, A alternating
// - Codes 101 toggle PWM, 100 no toggle
// - Toggle mode inverts pin A each underflow
// - PWM underflows set pending A, B alternately
// - Enable A/B gate reload-A/reload-B interrupts
// - Enable one allows interrupt, zero blocks
// - Run bit starts/stops PWM and event counting
// - Codes 000/001 event count, polarity per code
// - Event underflow sets pending A, gated A
// - Event mode pin B rising sets pending B
// - Event mode never drives pin A
// - Capture mode counter always runs
// - Pin edges copy counter into A/B
// - Codes 010,011,110,111 choose capture edges
// - Pin A falls only in 011/111, with B falling
// - Capture edges set pending A/B, gated
// - Capture underflow sets run bit, shares A
// - Timer bits at 7..4, cleared on reset
// - Counter and registers cleared to zero on reset
module multimode_timer_pwm_capture
  import timer_pkg::*;
#(
  parameter int CNT_W = `TMR_CNT_W,
  parameter int CYCLE_DIV = `TMR_CKI_DIV
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ctrl_wr,
  input wire logic [7:0] ctrl_wdata,
  input wire logic cnt_wr,
  input wire logic [CNT_W-1:0] cnt_wdata,
  input wire logic reg_a_wr,
  input wire logic reg_b_wr,
  input wire logic [CNT_W-1:0] reg_wdata,
  input wire logic clr_pending_a,
  input wire logic clr_pending_b,
  input wire logic irq_enable_a,
  input wire logic irq_enable_b,
  input wire logic timer_pin_a_in,
  input wire logic timer_pin_b,
  output logic timer_pin_a_out,
  output logic timer_pin_a_oe_n,
  output logic [7:0] timer_control_reg,
  output logic [CNT_W-1:0] main_counter,
  output logic [CNT_W-1:0] reload_capture_a,
  output logic [CNT_W-1:0] reload_capture_b,
  output logic pending_a,
  output logic pending_b,
  output logic irq_a,
  output logic irq_b
);

  // ****************************************
  // Mode decoding helpers
  // ****************************************

  // True for either PWM code
  function automatic logic is_pwm(input mode_code_type c);
    is_pwm = (c == CODE_PWM_PLAIN) || (c == CODE_PWM_TOGGLE);
  endfunction

  // True for either event counter code
  function automatic logic is_event(input mode_code_type c);
    is_event = (c == CODE_EVENT_RISE) || (c == CODE_EVENT_FALL);
  endfunction

  // True for every capture code
  function automatic logic is_capture(input mode_code_type c);
    is_capture = c[1];
  endfunction

  // Capture on falling edge of pin A
  function automatic logic cap_a_falls(input mode_code_type c);
    cap_a_falls = (c == CODE_CAP_FF) || (c == CODE_CAP_FF_ALT);
  endfunction

  // Capture on falling edge of pin B
  function automatic logic cap_b_falls(input mode_code_type c);
    cap_b_falls = (c == CODE_CAP_FF) || (c == CODE_CAP_FF_ALT) || (c == CODE_CAP_RF);
  endfunction

  // Pick a rising or falling edge pulse
  function automatic logic pick_edge(input logic falls, input logic rise, input logic fall);
    pick_edge = falls ? fall : rise;
  endfunction

  // ****************************************
  // Declarations
  // ****************************************

  logic [`TMR_PRESC_W-1:0] presc; // Instruction cycle divider
  logic tick; // One input clock per instruction cycle
  logic [3:0] ctrl_bits; // Mode 3..1 and run bit
  mode_code_type mode_code; // Current mode code
  logic run_bit; // Start bit or capture underflow flag
  logic pin_a_meta; // First synchroniser stage, pin A
  logic pin_a_sync; // Second synchroniser stage, pin A
  logic pin_a_prev; // Pin A at last instruction cycle
  logic pin_b_meta; // First synchroniser stage, pin B
  logic pin_b_sync; // Second synchroniser stage, pin B
  logic pin_b_prev; // Pin B at last instruction cycle
  logic rise_a; // Rising edge seen on pin A
  logic fall_a; // Falling edge seen on pin A
  logic rise_b; // Rising edge seen on pin B
  logic fall_b; // Falling edge seen on pin B
  logic mode_pwm; // PWM mode selected
  logic mode_event; // Event counter mode selected
  logic mode_cap; // Capture mode selected
  logic count_edge; // Selected counting edge on pin A
  logic cnt_zero; // Counter at zero
  logic uf_pwm; // PWM underflow
  logic uf_event; // Event counter underflow
  logic uf_cap; // Capture mode underflow
  logic cap_a; // Capture event on pin A
  logic cap_b; // Capture event on pin B
  reload_src_type reload_src; // Next PWM reload source
  logic [CNT_W-1:0] next_reload; // Value loaded at underflow
  logic we_a; // Write strobe for word A
  logic we_b; // Write strobe for word B
  logic [CNT_W-1:0] wdata_a; // Write data for word A
  logic [CNT_W-1:0] wdata_b; // Write data for word B

  // Control byte view; low bits belong to other blocks
  assign mode_code = mode_code_type'(ctrl_bits[3:1]);
  assign run_bit = ctrl_bits[0];

  // ****************************************
  // Instruction cycle tick
  // ****************************************

  // Divide the input clock down to the instruction cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      presc <= `TMR_PRESC_ZERO;
    end else if (presc == `TMR_PRESC_W'(CYCLE_DIV - 1)) begin
      presc <= `TMR_PRESC_ZERO;
    end else begin
      presc <= presc + `TMR_PRESC_ONE;
    end
  end

  // Tick on the last input clock of each instruction cycle
  assign tick = (presc == `TMR_PRESC_W'(CYCLE_DIV - 1));

  // ****************************************
  // Pin synchronisers and edge detectors
  // ****************************************

  // Two-stage synchronisers for both pins
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_a_meta <= 1'h0;
      pin_a_sync <= 1'h0;
      pin_b_meta <= 1'h0;
      pin_b_sync <= 1'h0;
    end else begin
      pin_a_meta <= timer_pin_a_in;
      pin_a_sync <= pin_a_meta;
      pin_b_meta <= timer_pin_b;
      pin_b_sync <= pin_b_meta;
    end
  end

  // Sample synchronised pins once per instruction cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_a_prev <= 1'h0;
      pin_b_prev <= 1'h0;
    end else if (tick) begin
      pin_a_prev <= pin_a_sync;
      pin_b_prev <= pin_b_sync;
    end
  end

  // One pulse per transition, aligned to the tick
  assign rise_a = tick & pin_a_sync & ~pin_a_prev;
  assign fall_a = tick & ~pin_a_sync & pin_a_prev;
  assign rise_b = tick & pin_b_sync & ~pin_b_prev;
  assign fall_b = tick & ~pin_b_sync & pin_b_prev;

  // ****************************************
  // Mode and event decode
  // ****************************************

  // Mode selection from bits 3..1
  assign mode_pwm = is_pwm(mode_code);
  assign mode_event = is_event(mode_code);
  assign mode_cap = is_capture(mode_code);

  // Event counting edge: code 000 rising, 001 falling
  assign count_edge = (mode_code == CODE_EVENT_FALL) ? fall_a : rise_a;

  // Underflow happens when a count arrives with the counter already at zero
  assign cnt_zero = (main_counter == `TMR_CNT_ZERO);
  assign uf_pwm = mode_pwm & run_bit & tick & cnt_zero;
  assign uf_event = mode_event & run_bit & count_edge & cnt_zero;
  assign uf_cap = mode_cap & tick & cnt_zero;

  // Capture events, polarity chosen per pin
  assign cap_a = mode_cap & pick_edge(cap_a_falls(mode_code), rise_a, fall_a);
  assign cap_b = mode_cap & pick_edge(cap_b_falls(mode_code), rise_b, fall_b);

  // Reload value: PWM alternates, event mode uses word A
  assign next_reload = (mode_pwm && reload_src == SRC_B) ? reload_capture_b : reload_capture_a;

  // ****************************************
  // Control register
  // ****************************************

  // Timer bits of the control byte; capture underflow sets run
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_bits <= `TMR_CTRL_RESET;
    end else begin
      if (ctrl_wr) begin
        // Software write of bits 7..4
        ctrl_bits <= {ctrl_wdata[`TMR_BIT_MODE3], ctrl_wdata[`TMR_BIT_MODE2],
                      ctrl_wdata[`TMR_BIT_MODE1], ctrl_wdata[`TMR_BIT_RUN]};
        if (uf_cap) begin
          // Hardware set wins over the write
          ctrl_bits[0] <= 1'h1;
        end
      end else if (uf_cap) begin
        // Run bit doubles as underflow flag in capture mode
        ctrl_bits[0] <= 1'h1;
      end
    end
  end

  // Readback of the control byte, low bits read zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      timer_control_reg <= 8'h00;
    end else begin
      timer_control_reg <= {ctrl_bits, 4'h0};
    end
  end

  // ****************************************
  // Main counter
  // ****************************************

  // Down counter with reload on underflow
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      main_counter <= `TMR_CNT_ZERO;
    end else if (cnt_wr) begin
      // Software load
      main_counter <= cnt_wdata;
    end else if (uf_pwm || uf_event) begin
      // Reload at underflow
      main_counter <= next_reload;
    end else if (mode_pwm && run_bit && tick) begin
      // PWM counts instruction cycles
      main_counter <= main_counter - `TMR_CNT_ONE;
    end else if (mode_event && run_bit && count_edge) begin
      // Event mode counts pin A edges
      main_counter <= main_counter - `TMR_CNT_ONE;
    end else if (mode_cap && tick) begin
      // Free run, wraps past zero
      main_counter <= main_counter - `TMR_CNT_ONE;
    end
  end

  // PWM reload source: A after start, then alternate
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reload_src <= SRC_A;
    end else if (!(mode_pwm && run_bit)) begin
      // Stopped: next start begins with A
      reload_src <= SRC_A;
    end else if (uf_pwm) begin
      // Alternate on every underflow
      reload_src <= (reload_src == SRC_A) ? SRC_B : SRC_A;
    end
  end

  // ****************************************
  // Reload / capture words
  // ****************************************

  // Capture overrides a software write in the same cycle
  assign we_a = reg_a_wr | cap_a;
  assign we_b = reg_b_wr | cap_b;
  assign wdata_a = cap_a ? main_counter : reg_wdata;
  assign wdata_b = cap_b ? main_counter : reg_wdata;

  // Storage for both words
  reload_capture_regs #(
    .WIDTH(CNT_W)
  ) u_words (
    .clk(clk),
    .rst_n(rst_n),
    .we_a(we_a),
    .we_b(we_b),
    .wdata_a(wdata_a),
    .wdata_b(wdata_b),
    .rdata_a(reload_capture_a),
    .rdata_b(reload_capture_b)
  );

  // ****************************************
  // Pin A output
  // ****************************************

  // Toggle level on each underflow in toggle mode
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      timer_pin_a_out <= 1'h0;
    end else if (uf_pwm && mode_code == CODE_PWM_TOGGLE) begin
      timer_pin_a_out <= ~timer_pin_a_out;
    end
  end

  // Drive pin A only in toggle mode; input otherwise
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      timer_pin_a_oe_n <= 1'h1;
    end else begin
      timer_pin_a_oe_n <= (mode_code != CODE_PWM_TOGGLE);
    end
  end

  // ****************************************
  // Pending flags
  // ****************************************

  // Flag A: reload-A underflow, event underflow, pin A capture
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pending_a <= 1'h0;
    end else if ((uf_pwm && reload_src == SRC_A) || uf_event || cap_a) begin
      // Set wins over a clear
      pending_a <= 1'h1;
    end else if (clr_pending_a) begin
      pending_a <= 1'h0;
    end
  end

  // Flag B: reload-B underflow, pin B rising, pin B capture
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pending_b <= 1'h0;
    end else if ((uf_pwm && reload_src == SRC_B) || (mode_event && rise_b) || cap_b) begin
      // Set wins over a clear
      pending_b <= 1'h1;
    end else if (clr_pending_b) begin
      pending_b <= 1'h0;
    end
  end

  // ****************************************
  // Interrupt requests
  // ****************************************

  // Request A also covers the capture underflow flag
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_a <= 1'h0;
    end else begin
      irq_a <= irq_enable_a & (pending_a | (mode_cap & run_bit));
    end
  end

  // Request B gated by its own enable
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_b <= 1'h0;
    end else begin
      irq_b <= irq_enable_b & pending_b;
    end
  end

endmodule
`default_nettype wire

// ---- logic/reload_capture_regs.sv ----
// Two reload/capture words with registered read data
`timescale 1ns/1ps
`default_nettype none
`include "timer_params.svh"

module reload_capture_regs #(
  parameter int WIDTH = `TMR_CNT_W
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic we_a,
  input wire logic we_b,
  input wire logic [WIDTH-1:0] wdata_a,
  input wire logic [WIDTH-1:0] wdata_b,
  output logic [WIDTH-1:0] rdata_a,
  output logic [WIDTH-1:0] rdata_b
);

  // ****************************************
  // Storage
  // ****************************************

  // Word A, read data is the stored word itself
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_a <= '0;
    end else if (we_a) begin
      rdata_a <= wdata_a;
    end
  end

  // Word B, same arrangement
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_b <= '0;
    end else if (we_b) begin
      rdata_b <= wdata_b;
    end
  end

endmodule
`default_nettype wire
